// file: shared/qpt_pkg.sv
// Constants and types shared by the quadrature position tracker files
package qpt_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_LINES = 3;  // Camera input lines
    localparam int SEL_W = 2;  // Line select width
    localparam int DB_W = 16;  // Debounce interval width, in us
    localparam int POS_W = 32;  // Position counter width
    localparam int HYST_W = 16;  // Hysteresis threshold width
    localparam int ADDR_W = 8;  // Decoded byte address bits
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HYST = 8'h04;
    localparam logic [7:0] OFS_CLEAR = 8'h08;
    localparam logic [7:0] OFS_POS = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_DB0 = 8'h14;  // Line i at +4*i
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_W = 10;
    localparam int B_BOTH = 0;  // count_both_ways
    localparam int B_PHASE = 1;  // phase_line_select, 2 bits
    localparam int B_QUAD = 3;  // quadrature_line_select, 2 bits
    localparam int B_ZLINE = 5;  // zeroing_line_select, 2 bits
    localparam int B_ZEDGE = 7;  // zeroing_edge_mode
    localparam int B_ZFLIP = 8;  // zeroing_polarity_flip
    localparam int B_ZSRC = 9;  // zeroing_source_select
    localparam int B_CLEAR = 0;  // Software clear command bit
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h008;
    localparam logic [HYST_W-1:0] HYST_RST = 16'h0001;
    localparam logic [DB_W-1:0] DB_RST = 16'h0000;
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;  // 250 MHz
    localparam int US_NS = 1000;  // Debounce time unit
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // Bus answers and modes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {QPT_ZSRC_SOFTWARE, QPT_ZSRC_EXTERNAL} qpt_zsrc_t;
endpackage

// file: hdl/qpt_debounce.sv
// Per-line debouncing filter of the quadrature position tracker
`timescale 1ns/100ps
module qpt_debounce import qpt_pkg::*; #(
    parameter int W = DB_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic raw,
    input wire logic us_tick,
    input wire logic [W-1:0] interval,
    output logic clean
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic clean;  // Filtered level
        logic last;  // Previous raw sample
        logic [W-1:0] cnt;  // Stable time in us
    } qpt_db_t;

    qpt_db_t s_reg;
    qpt_db_t s_next;

    // Level passes after interval us ticks of stable input, up to one us early
    always_comb begin
        s_next = s_reg;
        s_next.last = raw;
        if (interval == '0) begin
            // Zero interval: filter bypassed
            s_next.clean = raw;
            s_next.cnt = '0;
        end else if (raw != s_reg.last || raw == s_reg.clean) begin
            // Any movement restarts the stable time
            s_next.cnt = '0;
        end else if (us_tick) begin
            // Granularity is one us, so the wait may run short by <1us
            if (s_reg.cnt + 1'b1 >= interval) begin
                s_next.clean = raw;
                s_next.cnt = '0;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign clean = s_reg.clean;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_db_bypass;
        @(posedge aclk) disable iff (!aresetn)
        (interval == '0) |=> (clean == $past(raw));
    endproperty
    a_db_bypass: assert property (p_db_bypass)
        else $error("bypassed debouncer did not follow input");
endmodule

// file: hdl/qpt_tracker.sv
// Quadrature position tracker: encoder decode, ticks and register slave
// Overview of operation
// - Each valid transition moves position; ticks follow the mode
// - Phase and quadrature each select any line
// - Encoder sees debounced lines, never raw ones
// - Hysteresis hides short reversals from ticks
// - Count-both-ways mode ticks in either direction
// - Forward-only mode: backward motion decrements position, no tick
// - Ticks resume once lost ground is regained
// - Position readable anytime as 32-bit unsigned
// - Read returns position at request moment
// - Software or external input zeroes position
// - Zeroing also restarts trigger target counting
// - External zeroing: line, edge and polarity options
// - Edge mode, no flip: zero on rise
// - Debouncer waits programmed interval; zero bypasses
`timescale 1ns/100ps
module qpt_tracker import qpt_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_LINES-1:0] line_in,
    output logic enc_tick,
    output logic [POS_W-1:0] enc_position,
    output logic enc_direction,
    output logic targets_clear,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;  // Mode and line selects
        logic [HYST_W-1:0] hyst;  // Reversal threshold, steps
        logic [NUM_LINES-1:0][DB_W-1:0] dbi;  // Debounce intervals
        logic [7:0] us_cnt;  // Microsecond prescaler
        logic us_tick;  // One pulse per us
        logic [1:0] prev_ab;  // Last phase/quadrature sample
        logic zl_prev;  // Last zeroing line level
        logic [POS_W-1:0] pos;  // Position counter
        logic [POS_W-1:0] back;  // Steps behind the high mark
        logic [HYST_W-1:0] exc;  // Steps against accepted way
        logic dir;  // Accepted direction, 1 = forward
        logic tick;  // Tick pulse
        logic tclr;  // Target restart pulse
        logic awready, wready;
        logic aw_got, w_got;  // Address and data held
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } qpt_state_t;
    qpt_state_t s_reg;
    qpt_state_t s_next;
    logic [NUM_LINES-1:0] clean;  // Debounced lines
    logic ph_a;  // Selected phase
    logic qd_b;  // Selected quadrature
    logic zl;  // Zeroing line after polarity
    logic step;  // One valid Gray step
    logic fwd;  // Step is forward
    logic ext_clr;  // External zeroing request
    logic both_ways;  // Count-both-ways mode
    qpt_zsrc_t zsrc;  // Zeroing source
    // ----------------------------------------------------------------
    // Debouncers, one per line
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_db
        qpt_debounce #(.W(DB_W)) u_db (.aclk(aclk), .aresetn(aresetn),
            .raw(line_in[i]), .us_tick(s_reg.us_tick),
            .interval(s_reg.dbi[i]), .clean(clean[i]));
    end
    // Select code beyond the last line falls back to line 0
    function automatic logic pick(input logic [NUM_LINES-1:0] v,
                                  input logic [SEL_W-1:0] sel);
        pick = (int'(sel) < NUM_LINES) ? v[sel] : v[0];
    endfunction
    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction
    // ----------------------------------------------------------------
    // Input selection and step decode
    // ----------------------------------------------------------------
    assign both_ways = s_reg.ctrl[B_BOTH];
    assign zsrc = qpt_zsrc_t'(s_reg.ctrl[B_ZSRC]);
    // Only filtered lines reach the decoder
    assign ph_a = pick(clean, s_reg.ctrl[B_PHASE +: SEL_W]);
    assign qd_b = pick(clean, s_reg.ctrl[B_QUAD +: SEL_W]);
    // A double change is illegal in Gray code and is dropped
    assign step = ph_a ^ qd_b ^ s_reg.prev_ab[1] ^ s_reg.prev_ab[0];
    // Phase leading quadrature counts as forward
    assign fwd = ph_a ^ s_reg.prev_ab[0];
    assign zl = pick(clean, s_reg.ctrl[B_ZLINE +: SEL_W])
              ^ s_reg.ctrl[B_ZFLIP];
    // Edge mode zeroes on a rise; level mode while high
    assign ext_clr = (zsrc == QPT_ZSRC_EXTERNAL)
                   && (s_reg.ctrl[B_ZEDGE] ? (zl && !s_reg.zl_prev)
                                           : zl);
    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic sw_clr;
        logic [31:0] wv, rv;
        logic hit;
        sw_clr = 1'b0;
        wv = '0;
        rv = '0;
        hit = 1'b0;
        s_next = s_reg;
        s_next.tick = 1'b0;
        s_next.tclr = 1'b0;
        // Microsecond prescaler for the debouncers
        if (int'(s_reg.us_cnt) == US_CYCLES - 1) begin
            s_next.us_cnt = '0;
            s_next.us_tick = 1'b1;
        end else begin
            s_next.us_cnt = s_reg.us_cnt + 8'h01;
            s_next.us_tick = 1'b0;
        end
        // Write response retires, channels reopen
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // Address and data taken in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_addr = s_axi_awaddr;
            s_next.aw_got = 1'b1;
            s_next.awready = 1'b0;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
            s_next.w_got = 1'b1;
            s_next.wready = 1'b0;
        end
        // Both halves held: perform the write
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            unique case ({s_reg.aw_addr[ADDR_W-1:2], 2'b00})
                OFS_CTRL: begin
                    wv = merge(32'(s_reg.ctrl), s_reg.w_data,
                               s_reg.w_strb);
                    s_next.ctrl = wv[CTRL_W-1:0];
                end
                OFS_HYST: begin
                    wv = merge(32'(s_reg.hyst), s_reg.w_data,
                               s_reg.w_strb);
                    s_next.hyst = wv[HYST_W-1:0];
                end
                OFS_CLEAR: begin
                    // Command only counts when software owns zeroing
                    sw_clr = s_reg.w_strb[0]
                           && s_reg.w_data[B_CLEAR]
                           && zsrc == QPT_ZSRC_SOFTWARE;
                end
                OFS_POS, OFS_STAT: begin  // Read-only, write ignored
                end
                default: begin
                    for (int i = 0; i < NUM_LINES; i++) begin
                        if (s_reg.aw_addr == ADDR_W'(OFS_DB0 + 4*i)) begin
                            wv = merge(32'(s_reg.dbi[i]), s_reg.w_data,
                                       s_reg.w_strb);
                            s_next.dbi[i] = wv[DB_W-1:0];
                            hit = 1'b1;
                        end
                    end
                    s_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
                end
            endcase
        end
        // Read response retires
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // Read data snapshot at the request edge
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFS_CTRL: rv = 32'(s_reg.ctrl);
                OFS_HYST: rv = 32'(s_reg.hyst);
                OFS_CLEAR: rv = '0;
                OFS_POS: rv = s_reg.pos;
                OFS_STAT: rv = {30'h0, s_reg.back != '0, s_reg.dir};
                default: begin
                    // A debounce write in this cycle must not mark a hit
                    hit = 1'b0;
                    for (int i = 0; i < NUM_LINES; i++) begin
                        if (s_axi_araddr == ADDR_W'(OFS_DB0 + 4*i)) begin
                            rv = 32'(s_reg.dbi[i]);
                            hit = 1'b1;
                        end
                    end
                    s_next.rresp = hit ? RESP_OKAY : RESP_SLVERR;
                end
            endcase
            s_next.rdata = rv;
        end
        // Encoder: zeroing outranks a step in the same cycle
        s_next.prev_ab = {ph_a, qd_b};
        s_next.zl_prev = zl;
        if (sw_clr || ext_clr) begin
            s_next.pos = POS_RST;
            s_next.back = '0;
            s_next.exc = '0;
            s_next.tclr = 1'b1;
        end else if (step) begin
            // Modulo 2^32 by natural wrap
            s_next.pos = fwd ? s_reg.pos + 1'b1
                             : s_reg.pos - 1'b1;
            if (both_ways) begin
                if (fwd == s_reg.dir) begin
                    // Climb back over any jitter before ticking
                    if (s_reg.exc == '0) begin
                        s_next.tick = 1'b1;
                    end else begin
                        s_next.exc = s_reg.exc - 1'b1;
                    end
                end else if (s_reg.exc >= s_reg.hyst) begin
                    // Reversal beyond threshold is accepted
                    s_next.dir = fwd;
                    s_next.exc = '0;
                    s_next.tick = 1'b1;
                end else begin
                    s_next.exc = s_reg.exc + 1'b1;
                end
            end else if (fwd) begin
                // Tick only on ground never covered before
                if (s_reg.back == '0) begin
                    s_next.tick = 1'b1;
                    s_next.dir = 1'b1;
                end else begin
                    s_next.back = s_reg.back - 1'b1;
                end
            end else begin
                s_next.back = s_reg.back + 1'b1;
                s_next.dir = 1'b0;
            end
        end
    end
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RST;
            s_reg.hyst <= HYST_RST;
            s_reg.dbi <= {NUM_LINES{DB_RST}};
            s_reg.pos <= POS_RST;
            s_reg.dir <= 1'b1;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign enc_tick = s_reg.tick;
    assign enc_position = s_reg.pos;
    assign enc_direction = s_reg.dir;
    assign targets_clear = s_reg.tclr;
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rvalid = s_reg.rvalid;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ext_zero;
        ext_clr |=> (enc_position == '0) && targets_clear;
    endproperty
    a_ext_zero: assert property (p_ext_zero)
        else $error("external zeroing missed");
    property p_rise_zero;
        (zsrc == QPT_ZSRC_EXTERNAL && s_reg.ctrl[B_ZEDGE]
         && !s_reg.ctrl[B_ZFLIP] && zl && !s_reg.zl_prev)
        |=> enc_position == '0;
    endproperty
    a_rise_zero: assert property (p_rise_zero)
        else $error("rising edge did not zero position");
    property p_fwd_inc;
        (step && fwd && !ext_clr && !(s_reg.aw_got && s_reg.w_got))
        |=> enc_position == $past(enc_position) + 32'h1;
    endproperty
    a_fwd_inc: assert property (p_fwd_inc)
        else $error("forward step did not increment");
    property p_back_dec;
        (step && !fwd && !both_ways && !ext_clr
         && !(s_reg.aw_got && s_reg.w_got))
        |=> enc_position == $past(enc_position) - 32'h1 && !enc_tick;
    endproperty
    a_back_dec: assert property (p_back_dec)
        else $error("backward step wrong");
    property p_no_resume;
        (step && fwd && !both_ways && s_reg.back != '0 && !ext_clr)
        |=> !enc_tick;
    endproperty
    a_no_resume: assert property (p_no_resume)
        else $error("tick before lost ground regained");
    property p_resume;
        (step && fwd && !both_ways && s_reg.back == '0 && !ext_clr
         && !(s_reg.aw_got && s_reg.w_got)) |=> enc_tick ##1 !enc_tick;
    endproperty
    a_resume: assert property (p_resume)
        else $error("tick missing on new ground");
    property p_double_change;
        (!step && (ph_a != s_reg.prev_ab[1]) && !ext_clr
         && !(s_reg.aw_got && s_reg.w_got))
        |=> enc_position == $past(enc_position) && !enc_tick;
    endproperty
    a_double_change: assert property (p_double_change)
        else $error("double change was counted");
    property p_read_snap;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_POS)
        |=> s_axi_rvalid && s_axi_rdata == $past(enc_position);
    endproperty
    a_read_snap: assert property (p_read_snap)
        else $error("position read not snapshot at request");
    property p_both_tick;
        (step && both_ways && fwd == s_reg.dir && s_reg.exc == '0
         && !ext_clr && !(s_reg.aw_got && s_reg.w_got)) |=> enc_tick;
    endproperty
    a_both_tick: assert property (p_both_tick)
        else $error("both-ways mode missed a tick");
endmodule

// file: verification/qpt_encoder_model.sv
// Behavioural quadrature encoder that drives phase and quadrature levels
`timescale 1ns/100ps
module qpt_encoder_model (
    input wire logic aclk,
    input wire logic step_fwd,
    input wire logic step_bwd,
    output logic phase,
    output logic quad
);
    // Gray position; forward order of (phase,quad) is 00,10,11,01
    logic [1:0] idx_reg = 2'h0;
    // One step per request, so only one line ever moves at a time
    always @(posedge aclk) begin
        if (step_fwd) begin
            idx_reg <= idx_reg + 2'h1;
        end else if (step_bwd) begin
            idx_reg <= idx_reg - 2'h1;
        end
    end
    assign phase = ^idx_reg;
    assign quad = idx_reg[1];
endmodule

// file: verification/tb_quadrature_position_tracker.sv
// Self-checking bench for the quadrature position tracker
`timescale 1ns/100ps
module tb_quadrature_position_tracker import qpt_pkg::*; ;
    // -----------------------------------------------------------------
    // Stimulus and observed signals
    // -----------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, sf = 1'b0, sb = 1'b0, zl = 1'b0;
    logic ph, qu, tick, dir, tclr, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, pos, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    int n_mismatch = 0, total_checks = 0, ticks = 0, clears = 0;
    // Clock: 4 ns period
    always #2 aclk = ~aclk;
    // Pulse counters count high cycles; tick and edge or software clear pulses last one cycle
    always @(posedge aclk) begin
        if (tick === 1'b1) ticks <= ticks + 1;
        if (tclr === 1'b1) clears <= clears + 1;
    end
    qpt_encoder_model u_qpt_encoder_model (.aclk(aclk), .step_fwd(sf),
        .step_bwd(sb), .phase(ph), .quad(qu));
    // Line 2 carries phase, line 1 quadrature, line 0 the zeroing input
    qpt_tracker u_qpt_tracker (.aclk(aclk), .aresetn(aresetn),
        .line_in({ph, qu, zl}), .enc_tick(tick), .enc_position(pos),
        .enc_direction(dir), .targets_clear(tclr),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask
    // Read: data and response taken at the edge that sees rvalid
    task automatic rdreg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // Encoder steps spaced well beyond the two-cycle decode latency
    task automatic step(input int n, input logic fwd);
        repeat (n) begin
            @(posedge aclk);
            sf <= fwd;
            sb <= ~fwd;
            @(posedge aclk);
            sf <= 1'b0;
            sb <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdreg(OFS_CTRL);
        chk(rd, {22'h0, CTRL_RST});
        rdreg(OFS_HYST);
        chk(rd, {16'h0, HYST_RST});
        rdreg(OFS_POS);
        chk(rd, POS_RST);
        rdreg(8'hFC);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        $display("test registers done");
        wr(OFS_CTRL, 32'h0000_000C);
        step(4, 1'b1);
        chk(pos, 32'h4);
        chk(ticks, 32'h4);
        step(2, 1'b0);
        chk(pos, 32'h2);
        chk(ticks, 32'h4);
        step(2, 1'b1);
        chk(ticks, 32'h4);
        step(1, 1'b1);
        chk(pos, 32'h5);
        chk(ticks, 32'h5);
        $display("test forward only done");
        wr(OFS_CTRL, 32'h0000_000D);
        step(1, 1'b0);
        chk(ticks, 32'h5);
        chk({31'h0, dir}, 32'h1);
        step(2, 1'b0);
        chk(ticks, 32'h7);
        chk({31'h0, dir}, 32'h0);
        chk(pos, 32'h2);
        $display("test both ways done");
        wr(OFS_CLEAR, 32'h1);
        repeat (2) @(posedge aclk);
        chk(pos, 32'h0);
        chk(clears, 32'h1);
        wr(OFS_CTRL, 32'h0000_028C);
        step(3, 1'b1);
        chk(pos, 32'h3);
        zl <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(pos, 32'h0);
        chk(clears, 32'h2);
        step(1, 1'b0);
        rdreg(OFS_POS);
        chk(rd, 32'hFFFF_FFFF);
        $display("test zeroing done");
        // One microsecond filter on the phase line delays the next step
        wr(OFS_DB0 + 8'h08, 32'h1);
        step(1, 1'b1);
        chk(pos, 32'hFFFF_FFFF);
        repeat (300) @(posedge aclk);
        chk(pos, 32'h0);
        $display("test debounce done");
        // Flipped edge mode: a falling line zeroes; then level mode holds
        wr(OFS_DB0 + 8'h08, 32'h0);
        wr(OFS_CTRL, 32'h0000_038C);
        step(2, 1'b1);
        chk(pos, 32'h2);
        zl <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(pos, 32'h0);
        chk(clears, 32'h3);
        wr(OFS_CTRL, 32'h0000_030C);
        step(1, 1'b1);
        chk(pos, 32'h0);
        zl <= 1'b1;
        step(1, 1'b1);
        chk(pos, 32'h1);
        $display("test polarity done");
        report_and_stop();
    end
    // Watchdog: the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
